/* core/hsf_pkg.sv */
// Types shared by the status flags block
package hsf_pkg;
    // Interrupt event positions in the controller-side event register
    typedef enum logic [0:0]
    {
        HSF_EV_CMD = 1'b0,
        HSF_EV_DATA = 1'b1
    } hsf_event_t;
endpackage

/* core/hsf_regs.svh */
// Register offsets, field positions and reset values of the status flags
`ifndef HSF_REGS_SVH
`define HSF_REGS_SVH

// ****************************************************************
// Host-side offsets
// ****************************************************************
`define HSF_HOST_DATA0 3'h0
`define HSF_HOST_DATA3 3'h3
`define HSF_HOST_CMD 3'h4
`define HSF_HOST_STATUS 3'h4

// ****************************************************************
// Controller-side offsets
// ****************************************************************
`define HSF_EC_STATUS 4'h0
`define HSF_EC_IRQ_STAT 4'h4
`define HSF_EC_IRQ_MASK 4'h8

// ****************************************************************
// Status field positions
// ****************************************************************
`define HSF_BIT_UHIGH 7
`define HSF_BIT_MGMT 6
`define HSF_BIT_OSQ 5
`define HSF_BIT_BURST 4
`define HSF_BIT_CMD 3
`define HSF_BIT_ULOW 2
`define HSF_BIT_IBF 1

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define HSF_STATUS_RST 8'h00
`define HSF_SW_MASK 8'hF4
`define HSF_IRQ_RST 2'h0

`endif

/* core/hsf_status.sv */
// Host-visible ACPI mailbox status flags, bits 7 down to 2 plus input full
//
// Summary of operation
// RULE1 - The host reads the status byte only, and it mirrors the controller-side status that firmware reads and writes.
// RULE2 - Bit 6 is the firmware flag for a pending management query.
// RULE3 - This block raises no management or system-control interrupt to the host.
// RULE4 - Bit 5 is the firmware flag for a pending operating-system query.
// RULE5 - Bit 4 is the burst flag, changed only by firmware.
// RULE6 - A host command write sets bit 3.
// RULE7 - A host write to any of the four data bytes clears bit 3.
// RULE8 - Firmware reads bit 3 to tell a new command from a data byte.
// RULE9 - A host command write also sets the input full flag.
// RULE10 - Bits 7 and 2 are plain firmware flags and all flags reset to zero.
`timescale 1ns/1ps
`include "hsf_regs.svh"

module hsf_status
    import hsf_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    // Host side
    input wire logic [2:0] HOST_ADDR,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    output logic [7:0] HOST_RDATA,
    // Controller side register port
    input wire logic [3:0] EC_ADDR,
    input wire logic [7:0] EC_WDATA,
    input wire logic EC_WR,
    input wire logic EC_RD,
    output logic [7:0] EC_RDATA,
    // Input full control from the neighbouring data path, and the controller interrupt
    input wire logic IBF_SET_DATA,
    input wire logic IBF_CLR,
    output logic INPUT_BUFFER_FULL,
    output logic EC_IRQ
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_mask_r;
    logic [7:0] host_rdata_r;
    logic [7:0] ec_rdata_r;
    logic host_cmd_wr;
    logic host_data_wr;
    logic ec_status_wr;
    logic ec_stat_wr;
    logic ec_mask_wr;
    logic [7:0] ec_rd_sel;
    logic [1:0] events;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Host status reads share one decode between read path and checks
    function automatic logic host_is_status(input logic [2:0] a);
        return a == `HSF_HOST_STATUS;
    endfunction

    // Host writes at 4 are commands, 0 to 3 are data lanes
    assign host_cmd_wr = HOST_WR && (HOST_ADDR == `HSF_HOST_CMD);
    assign host_data_wr = HOST_WR && (HOST_ADDR <= `HSF_HOST_DATA3); // RULE7
    assign ec_status_wr = EC_WR && (EC_ADDR == `HSF_EC_STATUS);
    assign ec_stat_wr = EC_WR && (EC_ADDR == `HSF_EC_IRQ_STAT);
    assign ec_mask_wr = EC_WR && (EC_ADDR == `HSF_EC_IRQ_MASK);
    assign events = {host_data_wr, host_cmd_wr};

    // ****************************************************************
    // Status byte
    // ****************************************************************
    // Firmware owns bits 7,6,5,4,2; hardware owns 3 and 1
    always_comb
    begin
        status_nxt = status_r;
        if (ec_status_wr)
        begin
            status_nxt = (status_r & ~`HSF_SW_MASK)
                | (EC_WDATA & `HSF_SW_MASK); // RULE2 RULE4 RULE5 RULE10
        end
        // Host command beats data; both cannot occur together
        if (host_cmd_wr)
        begin
            status_nxt[`HSF_BIT_CMD] = 1'b1; // RULE6
            status_nxt[`HSF_BIT_IBF] = 1'b1; // RULE9
        end
        else if (host_data_wr)
        begin
            status_nxt[`HSF_BIT_CMD] = 1'b0; // RULE7
        end
        // Set wins over a same-cycle clear of input full
        if (!host_cmd_wr && !IBF_SET_DATA && IBF_CLR)
        begin
            status_nxt[`HSF_BIT_IBF] = 1'b0;
        end
        else if (IBF_SET_DATA)
        begin
            status_nxt[`HSF_BIT_IBF] = 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            status_r <= `HSF_STATUS_RST; // RULE10
        else
            status_r <= status_nxt;
    end

    // ****************************************************************
    // Controller interrupt
    // ****************************************************************
    // Sticky events, cleared by writing one; set wins over clear
    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        if (ec_stat_wr)
            irq_stat_nxt = irq_stat_r & ~EC_WDATA[1:0];
        irq_stat_nxt = irq_stat_nxt | events;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            irq_stat_r <= `HSF_IRQ_RST;
            irq_mask_r <= `HSF_IRQ_RST;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            if (ec_mask_wr)
                irq_mask_r <= EC_WDATA[1:0];
        end
    end

    // Only the controller is interrupted, never the host
    assign EC_IRQ = |(irq_stat_r & irq_mask_r); // RULE3

    // ****************************************************************
    // Read data
    // ****************************************************************
    assign ec_rd_sel = (EC_ADDR == `HSF_EC_STATUS) ? status_r :
        (EC_ADDR == `HSF_EC_IRQ_STAT) ? {6'h00, irq_stat_r} :
        (EC_ADDR == `HSF_EC_IRQ_MASK) ? {6'h00, irq_mask_r} : 8'h00;

    // Host sees the same byte firmware sees; host writes never store
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            host_rdata_r <= 8'h00;
            ec_rdata_r <= 8'h00;
        end
        else
        begin
            host_rdata_r <= (HOST_RD && host_is_status(HOST_ADDR))
                ? status_r : 8'h00; // RULE1
            ec_rdata_r <= EC_RD ? ec_rd_sel : 8'h00;
        end
    end

    assign HOST_RDATA = host_rdata_r;
    assign EC_RDATA = ec_rdata_r;
    assign INPUT_BUFFER_FULL = status_r[`HSF_BIT_IBF];

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_CMD_SET: assert property (@(posedge CLK) disable iff (RST) // RULE6
        host_cmd_wr |=> status_r[`HSF_BIT_CMD])
        else $error("command write did not set command flag");
    AST_CMD_CLR: assert property (@(posedge CLK) disable iff (RST) // RULE7
        host_data_wr |=> !status_r[`HSF_BIT_CMD])
        else $error("data write did not clear command flag");
    AST_IBF_SET: assert property (@(posedge CLK) disable iff (RST) // RULE9
        host_cmd_wr |=> status_r[`HSF_BIT_IBF])
        else $error("command write did not set input full");
    AST_MIRROR: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (HOST_RD && HOST_ADDR == `HSF_HOST_STATUS) |=>
        HOST_RDATA == $past(status_r))
        else $error("host status read differs from controller status");
    AST_BURST_SW: assert property (@(posedge CLK) disable iff (RST) // RULE5
        !ec_status_wr |=> $stable(status_r[`HSF_BIT_BURST]))
        else $error("burst flag changed without firmware write");
    AST_MGMT_SW: assert property (@(posedge CLK) disable iff (RST) // RULE2
        ec_status_wr |=>
        status_r[`HSF_BIT_MGMT] == $past(EC_WDATA[`HSF_BIT_MGMT]))
        else $error("management flag not written by firmware");
    AST_OSQ_SW: assert property (@(posedge CLK) disable iff (RST) // RULE4
        ec_status_wr |=>
        status_r[`HSF_BIT_OSQ] == $past(EC_WDATA[`HSF_BIT_OSQ]))
        else $error("query flag not written by firmware");
    AST_USER: assert property (@(posedge CLK) disable iff (RST) // RULE10
        (!ec_status_wr && !HOST_WR) |=>
        $stable({status_r[`HSF_BIT_UHIGH], status_r[`HSF_BIT_ULOW]}))
        else $error("user flags changed without firmware write");
    AST_IRQ: assert property (@(posedge CLK) disable iff (RST) // RULE3
        (irq_mask_r == 2'h0) |-> !EC_IRQ)
        else $error("interrupt raised while fully masked");

    // Reset must clear every flag, checked one cycle after reset is sampled high
    AST_RST_STATUS: assert property (@(posedge CLK) // RULE10
        RST |=> (status_r == `HSF_STATUS_RST))
        else $error("status not cleared by reset");

    // Event and mask registers start empty after reset
    AST_RST_IRQ: assert property (@(posedge CLK) // RULE10
        RST |=> (irq_stat_r == 2'h0 && irq_mask_r == 2'h0))
        else $error("event registers not cleared by reset");

    // Bit 0 belongs to a neighbour and always reads zero here
    AST_BIT0_ZERO: assert property (@(posedge CLK) disable iff (RST) // RULE1
        status_r[0] == 1'b0)
        else $error("status bit 0 is not zero");

    // Host writes never land in the firmware flags
    AST_HOST_RO: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (HOST_WR && !ec_status_wr) |=> $stable(status_r & `HSF_SW_MASK))
        else $error("host write changed a firmware flag");

    // Query flags move only on a firmware write
    AST_OSQ_HOLD: assert property (@(posedge CLK) disable iff (RST) // RULE4
        !ec_status_wr |=> $stable(status_r[`HSF_BIT_OSQ]))
        else $error("query flag changed without firmware write");

    // Management flag moves only on a firmware write
    AST_MGMT_HOLD: assert property (@(posedge CLK) disable iff (RST) // RULE2
        !ec_status_wr |=> $stable(status_r[`HSF_BIT_MGMT]))
        else $error("management flag changed without firmware write");

    // Burst flag follows the firmware write data
    AST_BURST_WR: assert property (@(posedge CLK) disable iff (RST) // RULE5
        ec_status_wr |=>
        status_r[`HSF_BIT_BURST] == $past(EC_WDATA[`HSF_BIT_BURST]))
        else $error("burst flag not written by firmware");

    // Firmware cannot move the command flag; only host writes do
    AST_CMD_HOLD: assert property (@(posedge CLK) disable iff (RST) // RULE6
        !HOST_WR |=> $stable(status_r[`HSF_BIT_CMD]))
        else $error("command flag changed without host write");

    // A lone clear empties input full
    AST_IBF_CLR: assert property (@(posedge CLK) disable iff (RST) // RULE9
        (IBF_CLR && !IBF_SET_DATA && !host_cmd_wr) |=>
        !status_r[`HSF_BIT_IBF])
        else $error("input full not cleared");

    // A data arrival wins over a same-cycle clear
    AST_IBF_WIN: assert property (@(posedge CLK) disable iff (RST) // RULE9
        IBF_SET_DATA |=> status_r[`HSF_BIT_IBF])
        else $error("input full set lost to clear");

    // Input full holds with no set and no clear
    AST_IBF_HOLD: assert property (@(posedge CLK) disable iff (RST) // RULE9
        (!IBF_SET_DATA && !IBF_CLR && !host_cmd_wr) |=>
        $stable(status_r[`HSF_BIT_IBF]))
        else $error("input full changed on its own");

    // Command write latches its controller event
    AST_EV_CMD: assert property (@(posedge CLK) disable iff (RST) // RULE6
        host_cmd_wr |=> irq_stat_r[HSF_EV_CMD])
        else $error("command event not recorded");

    // Data write latches its controller event
    AST_EV_DATA: assert property (@(posedge CLK) disable iff (RST) // RULE7
        host_data_wr |=> irq_stat_r[HSF_EV_DATA])
        else $error("data event not recorded");

    // Writing one clears an event when no new one arrives
    AST_EV_W1C: assert property (@(posedge CLK) disable iff (RST) // RULE3
        (ec_stat_wr && EC_WDATA[0] && !host_cmd_wr) |=>
        !irq_stat_r[HSF_EV_CMD])
        else $error("command event not cleared by write of one");

    // An unmasked command event must reach the controller
    AST_IRQ_ON: assert property (@(posedge CLK) disable iff (RST) // RULE3
        (irq_mask_r[0] && irq_stat_r[0]) |-> EC_IRQ)
        else $error("unmasked event gave no interrupt");

    // Controller status read shows the stored byte
    AST_EC_MIRROR: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (EC_RD && EC_ADDR == `HSF_EC_STATUS) |=>
        EC_RDATA == $past(status_r))
        else $error("controller status read differs from flags");

    // Unmapped controller reads return zero
    AST_EC_UNMAP: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (EC_RD && EC_ADDR != `HSF_EC_STATUS && EC_ADDR != `HSF_EC_IRQ_STAT
        && EC_ADDR != `HSF_EC_IRQ_MASK) |=> EC_RDATA == 8'h00)
        else $error("unmapped controller read not zero");

    // Host reads away from the status offset return zero
    AST_HOST_OTHER: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (HOST_RD && !host_is_status(HOST_ADDR)) |=> HOST_RDATA == 8'h00)
        else $error("host read of other offset not zero");

endmodule // hsf_status

/* tb/hsf_host_model.sv */
// Host driver model that issues mailbox writes and status reads
`timescale 1ns/1ps

module hsf_host_model
(
    input wire logic CLK,
    output logic [2:0] HOST_ADDR,
    output logic HOST_WR,
    output logic HOST_RD,
    input wire logic [7:0] HOST_RDATA
);
    // Idle bus from time zero
    initial
    begin
        HOST_ADDR = 3'h0;
        HOST_WR = 1'b0;
        HOST_RD = 1'b0;
    end

    // One-cycle write; the extra edge keeps back-to-back calls legal
    task automatic put(input logic [2:0] a);
        HOST_ADDR <= a;
        HOST_WR <= 1'b1;
        @(posedge CLK);
        HOST_WR <= 1'b0;
        @(posedge CLK);
    endtask

    // Read only: the host never expects a write to land in status
    task automatic get(input logic [2:0] a, output logic [7:0] d);
        HOST_ADDR <= a;
        HOST_RD <= 1'b1;
        @(posedge CLK);
        HOST_RD <= 1'b0;
        #1 d = HOST_RDATA;
        @(posedge CLK);
    endtask
endmodule // hsf_host_model

/* tb/hsf_status_test.sv */
// Self-checking bench for the mailbox status flags
`timescale 1ns/1ps
`include "hsf_regs.svh"

module hsf_status_test;
    logic CLK, RST, EC_WR, EC_RD, IBF_SET_DATA, IBF_CLR, HOST_WR, HOST_RD;
    logic INPUT_BUFFER_FULL, EC_IRQ;
    logic [2:0] HOST_ADDR;
    logic [3:0] EC_ADDR;
    logic [7:0] HOST_RDATA, EC_WDATA, EC_RDATA, d;
    int bad_count = 0;
    int n_tests = 0;

    hsf_status i_hsf_status (.CLK(CLK), .RST(RST), .HOST_ADDR(HOST_ADDR),
        .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA),
        .EC_ADDR(EC_ADDR), .EC_WDATA(EC_WDATA), .EC_WR(EC_WR), .EC_RD(EC_RD),
        .EC_RDATA(EC_RDATA), .IBF_SET_DATA(IBF_SET_DATA), .IBF_CLR(IBF_CLR),
        .INPUT_BUFFER_FULL(INPUT_BUFFER_FULL), .EC_IRQ(EC_IRQ));
    hsf_host_model i_hsf_host_model (.CLK(CLK), .HOST_ADDR(HOST_ADDR),
        .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA));

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic conclude();
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic hst(input logic [7:0] e);
        i_hsf_host_model.get(`HSF_HOST_STATUS, d);
        chk8(d, e);
    endtask
    task automatic ec_wr(input logic [3:0] a, input logic [7:0] v);
        EC_ADDR <= a;
        EC_WDATA <= v;
        EC_WR <= 1'b1;
        @(posedge CLK);
        EC_WR <= 1'b0;
        @(posedge CLK);
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic ec_rd(input logic [3:0] a, input logic [7:0] e);
        EC_ADDR <= a;
        EC_RD <= 1'b1;
        @(posedge CLK);
        EC_RD <= 1'b0;
        #1 chk8(EC_RDATA, e);
        @(posedge CLK);
    endtask
    task automatic input_buffer_full(input logic s, input logic c);
        IBF_SET_DATA <= s;
        IBF_CLR <= c;
        @(posedge CLK);
        IBF_SET_DATA <= 1'b0;
        IBF_CLR <= 1'b0;
        @(posedge CLK);
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence
    // ****************************************************************
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    // Whole sequence is about 130 cycles
    initial
    begin
        repeat (3000) @(posedge CLK);
        bad_count++;
        conclude();
    end
    initial
    begin
        {RST, EC_WR, EC_RD, IBF_SET_DATA, IBF_CLR} = 5'h10;
        EC_ADDR = 4'h0;
        EC_WDATA = 8'h00;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        hst(8'h00);
        chk1(INPUT_BUFFER_FULL, 1'b0);
        // One firmware flag at a time, bits 2 to 7; bit 3 must not take
        for (int b = 2; b < 8; b++)
        begin
            ec_wr(`HSF_EC_STATUS, 8'h01 << b);
            hst((8'h01 << b) & `HSF_SW_MASK);
        end
        ec_wr(`HSF_EC_STATUS, 8'hFF);
        ec_rd(`HSF_EC_STATUS, 8'hF4);
        ec_wr(`HSF_EC_IRQ_MASK, 8'h03);
        chk1(EC_IRQ, 1'b0);
        ec_wr(`HSF_EC_STATUS, 8'h10);
        // Command then data on each lane, burst held by firmware
        for (int a = 0; a < 4; a++)
        begin
            i_hsf_host_model.put(`HSF_HOST_CMD);
            hst(8'h1A);
            ec_wr(`HSF_EC_STATUS, 8'h10);
            ec_rd(`HSF_EC_STATUS, 8'h1A);
            i_hsf_host_model.put(a[2:0]);
            hst(8'h12);
            chk1(EC_IRQ, 1'b1);
            ec_rd(`HSF_EC_IRQ_STAT, 8'h03);
            ec_wr(`HSF_EC_IRQ_STAT, 8'h03);
            chk1(EC_IRQ, 1'b0);
            input_buffer_full(1'b0, 1'b1);
            chk1(INPUT_BUFFER_FULL, 1'b0);
        end
        // Masked data event stays quiet until unmasked
        ec_wr(`HSF_EC_IRQ_MASK, 8'h01);
        i_hsf_host_model.put(`HSF_HOST_DATA3);
        chk1(EC_IRQ, 1'b0);
        ec_wr(`HSF_EC_IRQ_MASK, 8'h03);
        chk1(EC_IRQ, 1'b1);
        input_buffer_full(1'b1, 1'b0);
        chk1(INPUT_BUFFER_FULL, 1'b1);
        // Set and clear together: the set wins
        input_buffer_full(1'b0, 1'b1);
        input_buffer_full(1'b1, 1'b1);
        chk1(INPUT_BUFFER_FULL, 1'b1);
        ec_rd(4'hC, 8'h00);
        i_hsf_host_model.get(3'h5, d);
        chk8(d, 8'h00);
        // Mid-run reset wipes every flag
        ec_wr(`HSF_EC_STATUS, 8'hF4);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        hst(8'h00);
        chk1(EC_IRQ, 1'b0);
        chk1(INPUT_BUFFER_FULL, 1'b0);
        conclude();
    end
endmodule // hsf_status_test
